// file: hw/check_gen.sv
// serial check generator, x^8 + x^5 + x^4 + 1, lsb-first shift
`timescale 1ns/1ps
module check_gen
   import id_gate_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   check_if.gen port
);
   logic [7:0] crc_q;
   logic [7:0] crc_d;
   logic fb;
   always_comb begin
      fb = crc_q[0] ^ port.bit_in;
      crc_d = crc_q;
      if (port.clear) begin
         crc_d = CHECK_INIT;
      end else if (port.shift) begin
         // reflected form of the polynomial, feedback into bits 7, 3, 2
         crc_d = {fb, crc_q[7:1]} ^ ({8{fb}} & 8'h0c);
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc_q <= CHECK_INIT;
      end else begin
         crc_q <= crc_d;
      end
   end
   assign port.value = crc_q;
   assign port.zero = (crc_q == 8'h00);
endmodule

// file: hw/check_if.sv
// shift-in port of the check generator
`timescale 1ns/1ps
interface check_if;
   logic clear;
   logic shift;
   logic bit_in;
   logic [7:0] value;
   logic zero;
   modport gen (input clear, input shift, input bit_in, output value, output zero);
   modport user (output clear, output shift, output bit_in, input value, input zero);
endinterface

// file: hw/id_gate_pkg.sv
// constants for the identity rom, check generator and access gate
package id_gate_pkg;
   localparam int unsigned FAMILY_W = 8;
   localparam int unsigned SERIAL_W = 48;
   localparam int unsigned CHECK_W = 8;
   localparam int unsigned ID_W = 64;
   localparam int unsigned BODY_W = 56;
   localparam logic [7:0] CHECK_POLY = 8'h31;
   localparam logic [7:0] CHECK_INIT = 8'h00;
   localparam int unsigned PAGE_BITS = 256;
   localparam int unsigned PAGE_BYTES = 32;
   localparam int unsigned OFS_W = 5;
   localparam int unsigned NUM_PAGES = 17;
   localparam int unsigned ADDR_W = 16;
   localparam logic [6:0] BIT_CNT_RST = 7'h00;
   localparam logic [6:0] BIT_CNT_ID = 7'h40;
   localparam logic [6:0] BIT_CNT_BODY = 7'h38;
   localparam logic [7:0] CMD_READ_ID = 8'h01;
   localparam logic [7:0] CMD_MATCH_ID = 8'h02;
   localparam logic [7:0] CMD_SEARCH_ID = 8'h03;
   localparam logic [7:0] CMD_SKIP_ID = 8'h04;
   localparam logic [7:0] CMD_WRITE_PAD = 8'h11;
   localparam logic [7:0] CMD_READ_PAD = 8'h12;
   localparam logic [7:0] CMD_COPY_PAD = 8'h13;
   localparam logic [7:0] CMD_READ_MEM = 8'h14;
   localparam logic [7:0] FAMILY_CODE = 8'h5a;
   localparam logic [47:0] SERIAL_CODE = 48'h0000_1234_5678;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ROM = 5'b00010,
      ST_CRC = 5'b00100,
      ST_MEMCMD = 5'b01000,
      ST_COPY = 5'b10000
   } gate_state_t;
endpackage

// file: hw/id_rom_crc_access_gate.sv
// identity rom, check generator front end, access gate and scratchpad buffering
`timescale 1ns/1ps
module id_rom_crc_access_gate
   import id_gate_pkg::*;
#(
   parameter int unsigned PAGES = NUM_PAGES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic txn_start_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_i,
   input wire logic id_bit_req_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_req_i,
   output logic id_bit_o,
   output logic id_bit_valid_o,
   output logic unlocked_o,
   output logic cmd_reject_o,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic copy_busy_o
);
   ////////////////////////////////////////////////////////////////////////////
   // identity code and check generator
   logic [BODY_W-1:0] body;
   assign body = {SERIAL_CODE, FAMILY_CODE};
   check_if ck();
   check_gen u_check (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .port(ck)
   );
   gate_state_t st_q, st_d;
   logic cp_done;
   logic [6:0] cnt_q, cnt_d;
   logic id_bit_q, id_bit_d;
   logic id_v_q, id_v_d;
   logic unl_q, unl_d;
   logic rej_q, rej_d;
   logic [7:0] cmd_q, cmd_d;
   always_comb begin
      ck.clear = 1'b0;
      ck.shift = 1'b0;
      ck.bit_in = 1'b0;
      st_d = st_q;
      cnt_d = cnt_q;
      id_bit_d = id_bit_q;
      id_v_d = 1'b0;
      unl_d = unl_q;
      rej_d = 1'b0;
      cmd_d = cmd_q;
      if (txn_start_i) begin
         st_d = ST_ROM;
         unl_d = 1'b0;
         cnt_d = BIT_CNT_RST;
         ck.clear = 1'b1;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (cmd_valid_i) begin
                  rej_d = 1'b1;
               end
            end
            ST_ROM: begin
               if (cmd_valid_i) begin
                  cmd_d = cmd_i;
                  case (cmd_i)
                     CMD_READ_ID: st_d = ST_CRC;
                     CMD_MATCH_ID, CMD_SEARCH_ID, CMD_SKIP_ID: begin
                        // match/search arbitration sits in the link layer
                        st_d = ST_MEMCMD;
                        unl_d = 1'b1;
                     end
                     default: rej_d = 1'b1;
                  endcase
               end
            end
            ST_CRC: begin
               if (id_bit_req_i) begin
                  // lsb first: family, serial, then the generated check byte
                  if (cnt_q < BIT_CNT_BODY) begin
                     id_bit_d = body[cnt_q[5:0]];
                     ck.shift = 1'b1;
                     ck.bit_in = id_bit_d;
                  end else begin
                     id_bit_d = ck.value[cnt_q[2:0]];
                  end
                  id_v_d = 1'b1;
                  cnt_d = 7'(cnt_q + 7'h01);
                  if (cnt_d == BIT_CNT_ID) begin
                     st_d = ST_MEMCMD;
                     unl_d = 1'b1;
                  end
               end
               if (cmd_valid_i) begin
                  rej_d = 1'b1;
               end
            end
            ST_MEMCMD: begin
               if (cmd_valid_i) begin
                  cmd_d = cmd_i;
                  case (cmd_i)
                     CMD_COPY_PAD: st_d = ST_COPY;
                     CMD_WRITE_PAD, CMD_READ_PAD, CMD_READ_MEM: ;
                     default: rej_d = 1'b1;
                  endcase
               end
            end
            ST_COPY: begin
               if (cp_done) begin
                  st_d = ST_MEMCMD;
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // scratchpad and paged memory
   localparam int unsigned WORDS = PAGES * PAGE_BYTES;
   localparam int unsigned MA_W = $clog2(WORDS);
   logic [7:0] pad [PAGE_BYTES];
   logic [7:0] mem [WORDS];
   logic [ADDR_W-1:0] pad_tgt_q, pad_tgt_d;
   logic [OFS_W-1:0] cp_ofs_q, cp_ofs_d;
   logic [ADDR_W-1:0] cp_full;
   logic busy_q, busy_d;
   logic [7:0] rd_q, rd_d;
   logic rdv_q, rdv_d;
   logic [MA_W-1:0] cp_addr;
   logic [MA_W-1:0] rd_addr;
   assign cp_done = (st_q == ST_COPY) && (cp_ofs_q == OFS_W'(PAGE_BYTES - 1));
   assign cp_full = {pad_tgt_q[ADDR_W-1:OFS_W], cp_ofs_q};
   assign cp_addr = MA_W'(cp_full);
   assign rd_addr = MA_W'(addr_i);
   always_comb begin
      pad_tgt_d = pad_tgt_q;
      cp_ofs_d = cp_ofs_q;
      rd_d = rd_q;
      rdv_d = 1'b0;
      busy_d = (st_d == ST_COPY);
      if (st_q == ST_MEMCMD && cmd_q == CMD_WRITE_PAD && wr_valid_i) begin
         pad_tgt_d = addr_i;
      end
      if (st_q == ST_COPY) begin
         cp_ofs_d = OFS_W'(cp_ofs_q + 1'b1);
      end else begin
         cp_ofs_d = '0;
      end
      if (st_q == ST_MEMCMD && rd_req_i) begin
         rdv_d = 1'b1;
         if (cmd_q == CMD_READ_PAD) begin
            rd_d = pad[addr_i[OFS_W-1:0]];
         end else if (cmd_q == CMD_READ_MEM && 32'(addr_i) < WORDS) begin
            rd_d = mem[rd_addr];
         end else begin
            rd_d = 8'h00;
         end
      end
   end
   // storage arrays carry no reset: contents are data, not control
   always_ff @(posedge clk_i) begin
      if (st_q == ST_MEMCMD && cmd_q == CMD_WRITE_PAD && wr_valid_i) begin
         pad[addr_i[OFS_W-1:0]] <= wr_data_i;
      end
      // full address check, so a high page cannot fold onto a low one
      if (st_q == ST_COPY && 32'(cp_full) < WORDS) begin
         mem[cp_addr] <= pad[cp_ofs_q];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         cnt_q <= BIT_CNT_RST;
         id_bit_q <= 1'b0;
         id_v_q <= 1'b0;
         unl_q <= 1'b0;
         rej_q <= 1'b0;
         cmd_q <= 8'h00;
         pad_tgt_q <= '0;
         cp_ofs_q <= '0;
         rd_q <= 8'h00;
         rdv_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         id_bit_q <= id_bit_d;
         id_v_q <= id_v_d;
         unl_q <= unl_d;
         rej_q <= rej_d;
         cmd_q <= cmd_d;
         pad_tgt_q <= pad_tgt_d;
         cp_ofs_q <= cp_ofs_d;
         rd_q <= rd_d;
         rdv_q <= rdv_d;
         busy_q <= busy_d;
      end
   end
   assign id_bit_o = id_bit_q;
   assign id_bit_valid_o = id_v_q;
   assign unlocked_o = unl_q;
   assign cmd_reject_o = rej_q;
   assign rd_data_o = rd_q;
   assign rd_valid_o = rdv_q;
   assign copy_busy_o = busy_q;
endmodule

// file: tb/id_gate_checker.sv
// port assertions for the identity gate
`timescale 1ns/1ps
module id_gate_checker
   import id_gate_pkg::*;
#(
   parameter int unsigned PAGES = NUM_PAGES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic txn_start_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_i,
   input wire logic id_bit_req_i,
   input wire logic rd_req_i,
   input wire logic id_bit_o,
   input wire logic id_bit_valid_o,
   input wire logic unlocked_o,
   input wire logic cmd_reject_o,
   input wire logic rd_valid_o,
   input wire logic copy_busy_o
);
   logic [5:0] busy_cnt_q, busy_cnt_d;
   always_comb busy_cnt_d = copy_busy_o ? busy_cnt_q + 6'h01 : 6'h00;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) busy_cnt_q <= 6'h00;
      else busy_cnt_q <= busy_cnt_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_copy_cmd;
      cmd_valid_i && cmd_i == CMD_COPY_PAD && !copy_busy_o;
   endsequence
   AST_BIT_ANSWER: assert property (id_bit_valid_o |-> $past(id_bit_req_i)) else $error("bit without request");
   AST_LOCKED_READ: assert property (rd_valid_o |-> $past(unlocked_o && rd_req_i)) else $error("read while locked");
   AST_REJECT_CAUSE: assert property (cmd_reject_o |-> $past(cmd_valid_i)) else $error("reject without cmd");
   AST_RELOCK: assert property (txn_start_i |=> !unlocked_o) else $error("no relock");
   AST_UNLOCK_CAUSE: assert property ($rose(unlocked_o) |-> $past(cmd_valid_i || id_bit_req_i)) else $error("bad unlock");
   AST_COPY_RUN: assert property (s_copy_cmd ##1 $rose(copy_busy_o) |-> ##31 copy_busy_o ##1 !copy_busy_o) else $error("copy span");
   AST_COPY_LEN: assert property ($fell(copy_busy_o) |-> busy_cnt_q == 6'h20) else $error("copy not one page");
   AST_BUSY_QUIET: assert property (copy_busy_o && rd_req_i |=> !rd_valid_o) else $error("read during copy");
endmodule
bind id_rom_crc_access_gate id_gate_checker #(.PAGES(PAGES)) u_id_gate_checker (.*);

// file: tb/id_master_model.sv
// master-side receiver that checks the identity stream
`timescale 1ns/1ps
module id_master_model
   import id_gate_pkg::*;
(
   input wire logic clk_i,
   input wire logic clear_i,
   input wire logic bit_i,
   input wire logic bit_valid_i,
   output logic good_o
);
   logic [7:0] chk_q, chk_d;
   logic [6:0] cnt_q, cnt_d;
   always_comb begin
      chk_d = chk_q;
      cnt_d = cnt_q;
      if (clear_i) begin
         chk_d = CHECK_INIT;
         cnt_d = BIT_CNT_RST;
      end else if (bit_valid_i) begin
         chk_d = (chk_q >> 1) ^ ((chk_q[0] ^ bit_i) ? 8'h8c : 8'h00);
         cnt_d = cnt_q + 7'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      chk_q <= chk_d;
      cnt_q <= cnt_d;
   end
   assign good_o = (cnt_q == BIT_CNT_ID) && (chk_q == 8'h00);
endmodule

// file: tb/id_rom_crc_access_gate_test.sv
// self-checking bench for the identity gate
`timescale 1ns/1ps
module id_rom_crc_access_gate_test;
   import id_gate_pkg::*;
   logic clk_i, rst_n_i, txn_start_i, cmd_valid_i, id_bit_req_i, wr_valid_i, rd_req_i, good;
   logic id_bit_o, id_bit_valid_o, unlocked_o, cmd_reject_o, rd_valid_o, copy_busy_o;
   logic [7:0] cmd_i, wr_data_i, rd_data_o;
   logic [ADDR_W-1:0] addr_i;
   int errors, total_checks;
   id_rom_crc_access_gate #(.PAGES(NUM_PAGES)) u_id_rom_crc_access_gate (.*);
   id_master_model u_id_master_model (.clk_i(clk_i), .clear_i(txn_start_i), .bit_i(id_bit_o),
      .bit_valid_i(id_bit_valid_o), .good_o(good));
   ////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic start;
      @(negedge clk_i) txn_start_i = 1'b1;
      @(negedge clk_i) txn_start_i = 1'b0;
   endtask
   // reject pulse stands one cycle only: callers look at it on return
   task automatic cmd(input logic [7:0] c);
      @(negedge clk_i) cmd_valid_i = 1'b1;
      cmd_i = c;
      @(negedge clk_i) cmd_valid_i = 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_i) wr_valid_i = 1'b1;
      addr_i = a;
      wr_data_i = d;
      @(negedge clk_i) wr_valid_i = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] v, input logic [7:0] d);
      @(negedge clk_i) rd_req_i = 1'b1;
      addr_i = a;
      @(negedge clk_i) rd_req_i = 1'b0;
      cmp({7'h00, rd_valid_o}, v);
      if (v == 8'h01) cmp(rd_data_o, d);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_locked;
      cmd(CMD_READ_MEM);
      cmp({6'h00, cmd_reject_o, unlocked_o}, 8'h02);
      start;
      cmd(CMD_WRITE_PAD);
      cmp({6'h00, cmd_reject_o, unlocked_o}, 8'h02);
      $display("t_locked done");
   endtask
   task automatic t_read_id;
      logic [63:0] code;
      logic [7:0] c;
      c = CHECK_INIT;
      for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ (i < 8 ? FAMILY_CODE[i] : SERIAL_CODE[i-8])) ? 8'h8c : 8'h00);
      code = {c, SERIAL_CODE, FAMILY_CODE};
      start;
      cmd(CMD_READ_ID);
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_i) id_bit_req_i = 1'b1;
         @(negedge clk_i) id_bit_req_i = 1'b0;
         cmp({6'h00, id_bit_valid_o, id_bit_o}, {6'h00, 1'b1, code[i]});
         cmp({7'h00, unlocked_o}, {7'h00, i == 63});
      end
      // model takes the last bit one edge later
      @(negedge clk_i);
      cmp({7'h00, good}, 8'h01);
      $display("t_read_id done");
   endtask
   task automatic t_other_ids;
      logic [7:0] ids [3] = '{CMD_MATCH_ID, CMD_SEARCH_ID, CMD_SKIP_ID};
      foreach (ids[k]) begin
         start;
         cmd(ids[k]);
         cmp({6'h00, cmd_reject_o, unlocked_o}, 8'h01);
      end
      cmd(CMD_READ_ID);
      cmp({7'h00, cmd_reject_o}, 8'h01);
      $display("t_other_ids done");
   endtask
   task automatic t_pad;
      cmd(CMD_WRITE_PAD);
      wr(16'h0040, 8'ha5);
      wr(16'h005f, 8'h3c);
      cmd(CMD_READ_PAD);
      rd(16'h0040, 8'h01, 8'ha5);
      rd(16'h005f, 8'h01, 8'h3c);
      cmd(CMD_COPY_PAD);
      cmp({7'h00, copy_busy_o}, 8'h01);
      rd(16'h0040, 8'h00, 8'h00);
      repeat (29) @(negedge clk_i);
      cmp({7'h00, copy_busy_o}, 8'h01);
      @(negedge clk_i);
      cmp({7'h00, copy_busy_o}, 8'h00);
      cmd(CMD_READ_MEM);
      rd(16'h0040, 8'h01, 8'ha5);
      rd(16'h005f, 8'h01, 8'h3c);
      rd(16'h4000, 8'h01, 8'h00);
      cmd(8'hff);
      cmp({7'h00, cmd_reject_o}, 8'h01);
      $display("t_pad done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      #(25 * 5000);
      errors++;
      report_and_stop;
   end
   initial begin
      {rst_n_i, txn_start_i, cmd_valid_i, id_bit_req_i, wr_valid_i, rd_req_i} = 6'h00;
      {cmd_i, wr_data_i, addr_i} = 32'h0000_0000;
      errors = 0;
      total_checks = 0;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_locked;
      t_read_id;
      t_other_ids;
      t_pad;
      report_and_stop;
   end
endmodule
